// *** sdir_map.svh ***
// sdir_map.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the reclocker control files
`ifndef SDIR_MAP_SVH
`define SDIR_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SDIR_OFS_CTRL       12'h000
`define SDIR_OFS_STATUS     12'h004
`define SDIR_OFS_INT_STAT   12'h008
`define SDIR_OFS_INT_CLR    12'h00C
`define SDIR_OFS_INT_EN     12'h010

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SDIR_CTRL_FORCE_BYP 0
`define SDIR_CTRL_SOFT_MUTE 1
`define SDIR_ST_LOCK        0
`define SDIR_ST_BYPASS      1
`define SDIR_ST_MUTE        2
`define SDIR_ST_CLK_MODE    3
`define SDIR_ST_CLK_INVALID 4
`define SDIR_ST_SEL_LO      5
`define SDIR_ST_SEL_HI      6
`define SDIR_INT_LOCK_GAIN  0
`define SDIR_INT_LOCK_LOSS  1
`define SDIR_INT_CLK_BAD    2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SDIR_CTRL_RST       2'h0
`define SDIR_INT_EN_RST     3'h0
// pin defaults: sel 00, clock mode low, mute_n high, bypass low, rate ok
`define SDIR_PIN_RST        6'h04

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SDIR_CLK_KHZ        10000
`define SDIR_ACQ_TIME_MS    15
`define SDIR_LOSS_TIME_MS   1
`define SDIR_ACQ_CYCLES     (`SDIR_ACQ_TIME_MS * `SDIR_CLK_KHZ)
`define SDIR_LOSS_CYCLES    (`SDIR_LOSS_TIME_MS * `SDIR_CLK_KHZ)
`define SDIR_BIT_CYCLES     2

`endif

// *** sdir_pkg.sv ***
// sdir_pkg.sv: types shared by the reclocker control files
// assumes nothing beyond a SystemVerilog compiler
package sdir_pkg;

  // lock detector states, one-hot
  typedef enum logic [2:0]
  {
    SDIR_IDLE = 3'b001,
    SDIR_ACQ  = 3'b010,
    SDIR_LOCK = 3'b100
  } sdir_lock_state_type;

  typedef logic [31:0] sdir_word_type;

endpackage : sdir_pkg

// *** sdir_sync.sv ***
// sdir_sync.sv: two-flop synchroniser for a group of levels
// assumes levels slow against pclk
`timescale 1ns/10ps
`default_nettype none

module sdir_sync
#(
  parameter int          WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : sdir_sync

`default_nettype wire

// *** sdir_lock_det.sv ***
// sdir_lock_det.sv: lock detector on the selected serial stream
// assumes data_bit synchronous to pclk, restart pulsed on input change
`timescale 1ns/10ps
`default_nettype none

module sdir_lock_det
  import sdir_pkg::*;
#(
  parameter int ACQ_CYCLES  = 150000,
  parameter int LOSS_CYCLES = 10000
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic enable,
  input  wire logic restart,
  input  wire logic data_bit,
  // status
  output logic      locked
);

  localparam int CW = $clog2(ACQ_CYCLES + LOSS_CYCLES + 1);

  sdir_lock_state_type state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [CW-1:0] idle_r, idle_nxt;
  logic          prev_r;

  wire edge_seen = data_bit ^ prev_r;
  wire acq_done  = (cnt_r >= CW'(ACQ_CYCLES - 1));
  wire idle_done = (idle_r >= CW'(LOSS_CYCLES - 1));

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    idle_nxt  = edge_seen ? '0 : idle_r + CW'(1);
    if (!enable || restart)
    begin
      state_nxt = SDIR_IDLE;
      cnt_nxt   = '0;
    end
    else
    begin
      case (state_r)
        SDIR_IDLE:
        begin
          cnt_nxt = '0;
          if (edge_seen)
            state_nxt = SDIR_ACQ;
        end
        SDIR_ACQ:
        begin
          cnt_nxt = cnt_r + CW'(1);
          if (idle_done)
            state_nxt = SDIR_IDLE;
          else if (acq_done)
            state_nxt = SDIR_LOCK;  // [RULE_13]
        end
        SDIR_LOCK:
        begin
          if (idle_done)
            state_nxt = SDIR_IDLE;
        end
        default:
          state_nxt = SDIR_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= SDIR_IDLE;
      cnt_r   <= '0;
      idle_r  <= '0;
      prev_r  <= 1'b0;
      locked  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      idle_r  <= idle_nxt;
      prev_r  <= data_bit;
      locked  <= (state_nxt == SDIR_LOCK);
    end
  end

endmodule : sdir_lock_det

`default_nettype wire

// *** sdir_top.sv ***
// sdir_top.sv: reclocker output steering, lock timing, APB registers
// assumes serial inputs and control pins sampled on pclk, one bit per
// BIT_CYCLES clocks; outputs are differential true/complement pairs
//
// Function
// [RULE_01] retime the selected serial stream at the line data rate
// [RULE_02] retime transport streams at that rate just like video
// [RULE_03] four serial inputs, exactly one active, chosen by two select pins
// [RULE_04] select code 00..11 maps to input 0..3; pins default to input 0
// [RULE_05] clock mode high puts the recovered bit clock on second output
// [RULE_06] clock mode low puts a copy of retimed data on second output
// [RULE_07] clock mode pin defaults low, so second output carries data
// [RULE_08] mute input low mutes primary and second outputs
// [RULE_09] bypass active in clock mode mutes the second output
// [RULE_10] a muted output holds true low, complement high, no toggling
// [RULE_11] clock rising edge falls at the centre of each data bit
// [RULE_12] unsupported rate in auto bypass with clock mode flags clock invalid
// [RULE_13] lock rises no later than 15 ms after first input transition
// [RULE_14] two retimed differential outputs: primary data and switchable second
// [RULE_15] bypass pin forces pass-through; else bypass when unlocked or bad rate
// [RULE_16] lock stays low under forced bypass; mute input defaults high
// [RULE_17] control pins pass a two-flop synchroniser before they steer anything
`timescale 1ns/10ps
`default_nettype none
`include "sdir_map.svh"

module sdir_top
  import sdir_pkg::*;
#(
  parameter int ACQ_CYCLES  = `SDIR_ACQ_CYCLES,
  parameter int LOSS_CYCLES = `SDIR_LOSS_CYCLES,
  parameter int BIT_CYCLES  = `SDIR_BIT_CYCLES
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial inputs
  input  wire logic [3:0]  serial_inputs,
  // control pins
  input  wire logic        input_select_low,
  input  wire logic        input_select_high,
  input  wire logic        second_output_clock_mode,
  input  wire logic        output_mute_n,
  input  wire logic        bypass,
  input  wire logic        rate_unsupported,
  // serial outputs
  output logic             primary_serial_output_p,
  output logic             primary_serial_output_n,
  output logic             second_serial_output_p,
  output logic             second_serial_output_n,
  // indicators
  output logic             lock_indicator,
  output logic             clock_invalid,
  output logic             irq
);

  localparam int BW   = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;
  localparam int HALF = BIT_CYCLES / 2;

  // ----------------------------------------------------------------------
  // control pin synchroniser
  // ----------------------------------------------------------------------
  logic [5:0] pins_q;
  logic [1:0] sel_q;
  logic       clk_mode_q, mute_n_q, bypass_q, rate_bad_q;

  sdir_sync #(.WIDTH(6), .RST_VAL(`SDIR_PIN_RST)) u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({input_select_high, input_select_low, second_output_clock_mode,
                output_mute_n, bypass, rate_unsupported}),
    .sync_out (pins_q)
  );  // [RULE_17]

  assign sel_q      = pins_q[5:4];
  assign clk_mode_q = pins_q[3];  // [RULE_07]
  assign mute_n_q   = pins_q[2];  // [RULE_16]
  assign bypass_q   = pins_q[1];
  assign rate_bad_q = pins_q[0];

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic [2:0] int_stat_r, int_stat_nxt;
  logic [2:0] int_en_r;
  logic [1:0] sel_prev_r;
  logic       lock_prev_r, clk_bad_prev_r;

  // ----------------------------------------------------------------------
  // input selection and bypass decision
  // ----------------------------------------------------------------------
  wire sel_bit     = serial_inputs[sel_q];  // [RULE_03] [RULE_04]
  wire sel_change  = (sel_q != sel_prev_r);
  wire force_byp   = bypass_q | ctrl_r[`SDIR_CTRL_FORCE_BYP];
  wire mute_act    = ~mute_n_q | ctrl_r[`SDIR_CTRL_SOFT_MUTE];  // [RULE_08]
  wire locked;
  wire bypass_act  = force_byp | ~locked | rate_bad_q;  // [RULE_15]
  wire clk_bad_nxt = clk_mode_q & ~force_byp & rate_bad_q;  // [RULE_12]

  sdir_lock_det #(.ACQ_CYCLES(ACQ_CYCLES), .LOSS_CYCLES(LOSS_CYCLES)) u_lock
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (~force_byp),
    .restart  (sel_change),
    .data_bit (sel_bit),
    .locked   (locked)
  );

  // ----------------------------------------------------------------------
  // bit timing and retiming
  // ----------------------------------------------------------------------
  logic [BW-1:0] bit_cnt_r, bit_cnt_nxt;
  logic          retime_r, retime_nxt;
  logic          bitclk_r;

  wire bit_start = (bit_cnt_r == '0);
  assign bit_cnt_nxt = (bit_cnt_r == BW'(BIT_CYCLES - 1)) ? '0 : bit_cnt_r + BW'(1);
  // retimed path samples once per bit; bypass follows the input every clock
  assign retime_nxt = (bypass_act | bit_start) ? sel_bit : retime_r;  // [RULE_01] [RULE_02]

  // ----------------------------------------------------------------------
  // output steering
  // ----------------------------------------------------------------------
  wire sec_mute = mute_act | (clk_mode_q & bypass_act);  // [RULE_08] [RULE_09]
  wire sec_src  = clk_mode_q ? bitclk_r : retime_r;  // [RULE_05] [RULE_06]
  wire prim_nxt = mute_act ? 1'b0 : retime_r;  // [RULE_10]
  wire sec_nxt  = sec_mute ? 1'b0 : sec_src;  // [RULE_10]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_cnt_r <= '0;
      retime_r  <= 1'b0;
      bitclk_r  <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_nxt;
      retime_r  <= retime_nxt;
      // low while retimed data is fresh, rises half a bit after it moves
      bitclk_r  <= (bit_cnt_nxt == '0) | (bit_cnt_nxt > BW'(HALF));  // [RULE_11]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      primary_serial_output_p <= 1'b0;
      primary_serial_output_n <= 1'b1;
      second_serial_output_p  <= 1'b0;
      second_serial_output_n  <= 1'b1;
      lock_indicator          <= 1'b0;
      clock_invalid           <= 1'b0;
    end
    else
    begin
      primary_serial_output_p <= prim_nxt;  // [RULE_14]
      primary_serial_output_n <= ~prim_nxt;
      second_serial_output_p  <= sec_nxt;  // [RULE_14]
      second_serial_output_n  <= ~sec_nxt;
      lock_indicator          <= locked & ~force_byp;  // [RULE_16]
      clock_invalid           <= clk_bad_nxt;  // [RULE_12]
    end
  end

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire setup    = psel & ~penable;
  wire wr_fire  = psel & penable & pwrite & pready;
  wire hit_ctrl = (paddr == `SDIR_OFS_CTRL);
  wire hit_stat = (paddr == `SDIR_OFS_STATUS);
  wire hit_ist  = (paddr == `SDIR_OFS_INT_STAT);
  wire hit_iclr = (paddr == `SDIR_OFS_INT_CLR);
  wire hit_ien  = (paddr == `SDIR_OFS_INT_EN);
  wire mapped   = hit_ctrl | hit_stat | hit_ist | hit_iclr | hit_ien;
  wire bad_acc  = ~mapped | (pwrite & (hit_stat | hit_ist)) | (~pwrite & hit_iclr);

  sdir_word_type status_word;
  sdir_word_type rd_word;

  assign status_word = {25'h000_0000, sel_q, clock_invalid, clk_mode_q,
                        mute_act, bypass_act, lock_indicator};
  assign rd_word = hit_ctrl ? {30'h0000_0000, ctrl_r} :
                   hit_stat ? status_word :
                   hit_ist  ? {29'h0000_0000, int_stat_r} :
                   hit_ien  ? {29'h0000_0000, int_en_r} : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // interrupt events; a new event wins over a clear in the same cycle
  // ----------------------------------------------------------------------
  wire [2:0] int_set = {clk_bad_nxt & ~clk_bad_prev_r,
                        lock_prev_r & ~locked,
                        locked & ~lock_prev_r};
  wire [2:0] int_clr = (wr_fire & hit_iclr) ? pwdata[2:0] : 3'h0;
  assign int_stat_nxt = (int_stat_r & ~int_clr) | int_set;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r         <= `SDIR_CTRL_RST;
      int_en_r       <= `SDIR_INT_EN_RST;
      int_stat_r     <= 3'h0;
      sel_prev_r     <= 2'h0;
      lock_prev_r    <= 1'b0;
      clk_bad_prev_r <= 1'b0;
      irq            <= 1'b0;
    end
    else
    begin
      if (wr_fire & hit_ctrl)
        ctrl_r <= pwdata[1:0];
      if (wr_fire & hit_ien)
        int_en_r <= pwdata[2:0];
      int_stat_r     <= int_stat_nxt;
      sel_prev_r     <= sel_q;
      lock_prev_r    <= locked;
      clk_bad_prev_r <= clk_bad_nxt;
      irq            <= |(int_stat_nxt & (wr_fire & hit_ien ? pwdata[2:0] : int_en_r));
    end
  end

  // ----------------------------------------------------------------------
  // apb answer: one wait-free access phase after each setup
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & bad_acc;
      prdata  <= (setup & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

endmodule : sdir_top

`default_nettype wire

// *** sdir_top_chk.sv ***
// sdir_top_chk.sv: port-level assertions for the reclocker control block
// assumes bind into sdir_top, single pclk domain
`timescale 1ns/10ps
`default_nettype none

module sdir_top_chk
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // control pins
  input wire logic input_select_low,
  input wire logic input_select_high,
  input wire logic second_output_clock_mode,
  input wire logic output_mute_n,
  input wire logic bypass,
  input wire logic rate_unsupported,
  // outputs
  input wire logic primary_serial_output_p,
  input wire logic primary_serial_output_n,
  input wire logic second_serial_output_p,
  input wire logic second_serial_output_n,
  input wire logic lock_indicator,
  input wire logic clock_invalid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mute_primary: assert property (
    !output_mute_n [*6] |-> !primary_serial_output_p && primary_serial_output_n)
    else $error("primary output not muted");
  a_mute_second: assert property (
    !output_mute_n [*6] |-> !second_serial_output_p && second_serial_output_n)
    else $error("second output not muted");
  a_pair_opposite: assert property (
    primary_serial_output_p != primary_serial_output_n && second_serial_output_p != second_serial_output_n)
    else $error("output pair not opposite");
  a_clk_bypass_mute: assert property (
    (second_output_clock_mode && bypass) [*6] |-> !second_serial_output_p && second_serial_output_n)
    else $error("clock output not muted in bypass");
  a_lock_forced_low: assert property (
    bypass [*6] |-> !lock_indicator)
    else $error("lock high under forced bypass");
  a_clk_invalid_set: assert property (
    (second_output_clock_mode && rate_unsupported && !bypass) [*6] |-> clock_invalid)
    else $error("clock invalid not flagged");
  a_clk_invalid_data: assert property (
    !second_output_clock_mode [*6] |-> !clock_invalid)
    else $error("clock invalid in data mode");
  a_sel_restart: assert property (
    $changed({input_select_high, input_select_low}) |-> ##[1:8] !lock_indicator)
    else $error("lock kept over select change");
  a_clock_toggles: assert property (
    (second_output_clock_mode && lock_indicator && !rate_unsupported && output_mute_n) [*6]
    |-> second_serial_output_p != $past(second_serial_output_p))
    else $error("bit clock not toggling");
  a_clock_centred: assert property (
    (second_output_clock_mode && lock_indicator && !rate_unsupported && output_mute_n && !bypass) [*6]
    ##0 $rose(second_serial_output_p) |-> $stable(primary_serial_output_p))
    else $error("clock edge not at data centre");
  a_apb_ready_once: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");
endmodule : sdir_top_chk

bind sdir_top sdir_top_chk u_sdir_top_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .input_select_low, .input_select_high, .second_output_clock_mode, .output_mute_n, .bypass,
  .rate_unsupported, .primary_serial_output_p, .primary_serial_output_n, .second_serial_output_p,
  .second_serial_output_n, .lock_indicator, .clock_invalid);

`default_nettype wire

// *** sdir_eq_model.sv ***
// sdir_eq_model.sv: upstream equalizer model driving the four serial lanes
// assumes pclk-synchronous lanes, one bit per BIT_CYCLES clocks
`timescale 1ns/10ps
`default_nettype none

module sdir_eq_model
#(
  parameter int BIT_CYCLES = 2
)
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench control
  input  wire logic       run,
  input  wire logic [3:0] hold_val,
  // lanes towards the block
  output logic      [3:0] serial_inputs
);
  int   seed = 62;
  int   cnt;
  logic alt;

  // random bits, forced edge every second bit so lock never drops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt           <= 0;
      alt           <= 1'b0;
      serial_inputs <= hold_val;
    end
    else
    begin
      cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
      if (cnt == 0)
        alt <= ~alt;
      if (!run)
        serial_inputs <= hold_val;
      else if (cnt == 0)
        serial_inputs <= alt ? ~serial_inputs : 4'($random(seed));
    end
  end
endmodule : sdir_eq_model

`default_nettype wire

// *** tb.sv ***
// tb.sv: self-checking bench for sdir_top
// assumes sdir_eq_model as lane source and the bound checker
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam int ACQ = 20;
  localparam int LOSS = 8;
  localparam int BITC = 2;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, d;
  logic        pready, pslverr, err, run = 0, p0;
  logic [3:0]  serial_inputs, hold_val = '0;
  logic        input_select_low = 0, input_select_high = 0, second_output_clock_mode = 0;
  logic        output_mute_n = 1, bypass = 0, rate_unsupported = 0;
  logic        primary_serial_output_p, primary_serial_output_n, second_serial_output_p;
  logic        second_serial_output_n, lock_indicator, clock_invalid, irq;
  int          bad_count = 0, checked = 0, cycles = 0, seed = 62, n;

  sdir_top #(.ACQ_CYCLES(ACQ), .LOSS_CYCLES(LOSS), .BIT_CYCLES(BITC)) u_sdir_top (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_inputs,
    .input_select_low, .input_select_high, .second_output_clock_mode, .output_mute_n, .bypass,
    .rate_unsupported, .primary_serial_output_p, .primary_serial_output_n, .second_serial_output_p,
    .second_serial_output_n, .lock_indicator, .clock_invalid, .irq);
  sdir_eq_model #(.BIT_CYCLES(BITC)) u_sdir_eq_model (.pclk, .presetn, .run, .hold_val, .serial_inputs);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  always #50 pclk = ~pclk;

  task finish_test();
    $display("counts: checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end

  function logic [1:0] pair(input logic v);
    return {v, ~v};
  endfunction : pair

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task wt(input int k);
    repeat (k) @(posedge pclk);
  endtask : wt

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    wt(2);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(lock_indicator, 0, "lock after reset");
    chk({primary_serial_output_p, primary_serial_output_n}, pair(0), "primary after reset");
    apb(0, 12'h000, 0);
    chk(rd, 0, "ctrl reset");
    apb(0, 12'h010, 0);
    chk(rd, 0, "int_en reset");
    $display("test reset done");
    for (int c = 0; c < 4; c++)
      for (int v = 0; v < 2; v++)
      begin
        d[3:0] = v ? ~(4'b1 << c) : (4'b1 << c);
        hold_val <= d[3:0];
        {input_select_high, input_select_low} <= 2'(c);
        wt(10);
        chk({primary_serial_output_p, primary_serial_output_n}, pair(d[c]), "selected lane");
        chk({second_serial_output_p, second_serial_output_n}, pair(d[c]), "second copy");
      end
    $display("test select done");
    {input_select_high, input_select_low} <= 2'($random(seed));
    apb(1, 12'h010, 1);
    run <= 1'b1;
    n = 0;
    while (lock_indicator !== 1'b1 && n < ACQ + 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n <= ACQ + 10), 1, "lock time");
    chk(irq, 1, "irq on lock");
    apb(0, 12'h008, 0);
    chk(rd & 7, 1, "lock gained sticky");
    apb(0, 12'h004, 0);
    chk(rd, {25'h000_0000, input_select_high, input_select_low, 5'h01}, "status locked");
    repeat (4)
    begin
      d = $random(seed);
      apb(1, 12'h010, d);
      apb(0, 12'h010, 0);
      chk(rd, d & 7, "int_en readback");
      wt(2);
      chk(irq, d[0], "irq mask");
    end
    apb(1, 12'h00C, 7);
    wt(2);
    chk(irq, 0, "irq cleared");
    apb(0, 12'h008, 0);
    chk(rd, 0, "status cleared");
    apb(0, 12'h020, 0);
    chk({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
    apb(1, 12'h004, 1);
    chk(err, 1, "status write");
    {input_select_high, input_select_low} <= ~{input_select_high, input_select_low};
    wt(6);
    chk(lock_indicator, 0, "lock restart on select");
    wt(ACQ + 16);
    chk(lock_indicator, 1, "relock after select");
    apb(0, 12'h008, 0);
    chk(rd, 3, "restart sticky");
    apb(1, 12'h00C, 7);
    $display("test lock and irq done");
    second_output_clock_mode <= 1'b1;
    wt(8);
    p0 = second_serial_output_p;
    @(posedge pclk);
    chk(second_serial_output_p, {31'h0000_0000, ~p0}, "bit clock toggles");
    rate_unsupported <= 1'b1;
    wt(8);
    chk(clock_invalid, 1, "clock invalid");
    chk({second_serial_output_p, second_serial_output_n}, pair(0), "auto bypass mute");
    rate_unsupported <= 1'b0;
    bypass <= 1'b1;
    wt(8);
    chk(lock_indicator, 0, "lock under bypass");
    chk({second_serial_output_p, second_serial_output_n}, pair(0), "forced bypass mute");
    apb(0, 12'h008, 0);
    chk(rd, 6, "lock lost and clock bad sticky");
    second_output_clock_mode <= 1'b0;
    bypass <= 1'b0;
    wt(8);
    chk(clock_invalid, 0, "clock invalid gone");
    $display("test clock mode done");
    output_mute_n <= 1'b0;
    wt(8);
    repeat (3)
    begin
      @(posedge pclk);
      chk({primary_serial_output_p, primary_serial_output_n}, pair(0), "primary muted");
      chk({second_serial_output_p, second_serial_output_n}, pair(0), "second muted");
    end
    output_mute_n <= 1'b1;
    apb(1, 12'h000, 2);
    wt(8);
    chk({primary_serial_output_p, primary_serial_output_n}, pair(0), "soft mute");
    apb(1, 12'h000, 0);
    wt(ACQ + 16);
    chk(lock_indicator, 1, "relock after bypass");
    apb(1, 12'h000, 1);
    wt(8);
    chk(lock_indicator, 0, "register bypass");
    apb(1, 12'h000, 0);
    $display("test mute done");
    finish_test();
  end
endmodule : tb

`default_nettype wire
